/* shared/usbdma_pkg.sv */
// ****************************************
// Shared constants of the DMA slave port
// ****************************************
package usbdma_pkg;
  // Register byte offsets
  localparam logic [3:0] REG_CFG_OFF = 4'h0;
  localparam logic [3:0] REG_CNT_OFF = 4'h4;
  localparam logic [3:0] REG_STAT_OFF = 4'h8;
  // Configuration fields
  localparam int CFG_EPIDX_LSB = 0;
  localparam int CFG_EN_BIT = 4;
  localparam int CFG_CNTEN_BIT = 5;
  localparam int CFG_SHORT_BIT = 6;
  localparam int CFG_BURST_BIT = 7;
  localparam int CFG_WIDE_BIT = 8;
  localparam int CFG_DMA_REQUEST_OUT_POL_BIT = 9;
  localparam int CFG_DMA_ACKNOWLEDGE_IN_POL_BIT = 10;
  localparam int CFG_EOT_POL_BIT = 11;
  localparam int CFG_ACKMODE_BIT = 12;
  localparam int CFG_W = 13;
  // Status fields
  localparam int STAT_RUN_BIT = 16;
  localparam int STAT_DONE_BIT = 17;
  localparam int STAT_WHY_LSB = 18;
  // Reset values
  localparam logic [12:0] CFG_RESET = 13'h0000;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  // Burst length and endpoint code range
  localparam logic [4:0] BURST_MAX_BYTES = 5'h10;
  localparam logic [3:0] EP_FIRST_CODE = 4'h2;
  localparam logic [3:0] EP_LAST_CODE = 4'hf;
  // Reason a run ended
  localparam logic [1:0] END_PIN = 2'h0;
  localparam logic [1:0] END_COUNT = 2'h1;
  localparam logic [1:0] END_SHORT = 2'h2;
  localparam logic [1:0] END_OFF = 2'h3;
  // Sequencer states, Gray along idle, run, drain
  typedef enum logic [1:0] {
    USBDMA_IDLE = 2'b00,
    USBDMA_RUN = 2'b01,
    USBDMA_DRAIN = 2'b11
  } usbdma_state_t;
endpackage : usbdma_pkg

/* logic/usbdma_sync.sv */
`timescale 1ns/1ps
// ****************************************
// Two flop synchroniser, one per bit
// ****************************************
module usbdma_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  // First stage is read only by the second
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  genvar b;
  generate
    for (b = 0; b < W; b++) begin : g_bit
      // Reset value is a constant, inputs are idle high pins
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          meta_q[b] <= 1'b1;
          sync_q[b] <= 1'b1;
        end else begin
          meta_q[b] <= d_i[b];
          sync_q[b] <= meta_q[b];
        end
      end
    end
  endgenerate
  assign q_o = sync_q;
endmodule : usbdma_sync

/* logic/usbdma_strobe.sv */
`timescale 1ns/1ps
// ****************************************
// Polarity fix and edge detect of strobes
// ****************************************
module usbdma_strobe #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] lvl_i,
  input wire logic [W-1:0] pol_i,
  output logic [W-1:0] act_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);
  // Previous active-true level
  logic [W-1:0] prev_q;
  genvar b;
  generate
    for (b = 0; b < W; b++) begin : g_bit
      // Pol high means the pin is active high
      assign act_o[b] = pol_i[b] ? lvl_i[b] : ~lvl_i[b];
      assign rise_o[b] = act_o[b] & ~prev_q[b];
      assign fall_o[b] = ~act_o[b] & prev_q[b];
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          prev_q[b] <= 1'b0;
        end else begin
          prev_q[b] <= act_o[b];
        end
      end
    end
  endgenerate
endmodule : usbdma_strobe

/* logic/usbdma_port.sv */
// Added by the designer: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
// ****************************************
// DMA slave port of the endpoint FIFOs
// ****************************************
// Notes on behaviour
// - One of fourteen endpoints serves DMA.
// - DMA interleaves with processor endpoint access.
// - Single or burst, burst up to 16.
// - Request, acknowledge, end polarity programmable.
// - Endpoint n encoded as n plus one.
// - Endpoint direction bit sets transfer direction.
// - Acknowledge routes access to DMA endpoint.
// - Mode bit: fly-by or acknowledge strobe.
// - Request when FIFO has data or room.
// - Fly-by strobes drive out or capture data.
// - Request drops per item or burst end.
// - Acknowledge release stops bus drive.
// - Acknowledge strobe mode ignores read/write strobes.
// - End-of-transfer pin stops DMA.
// - Byte counter loads, ends run at zero.
// - Pin end on receive flushes active buffer.
// - Short packet ends receive run.
// - Clearing enable stops, no interrupt.
module usbdma_port (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic dma_request_out_o,
  input wire logic dma_acknowledge_in_i,
  input wire logic end_of_transfer_in_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [15:0] bus_data_i,
  output logic [15:0] bus_data_o,
  output logic bus_data_oe_o,
  input wire logic [3:0] cpu_ep_select_i,
  output logic [3:0] dma_endpoint_index_o,
  input wire logic endpoint_direction_bit_i,
  input wire logic fifo_has_data_i,
  input wire logic fifo_has_room_i,
  input wire logic short_packet_i,
  input wire logic [15:0] fifo_rdata_i,
  output logic [3:0] dma_endpoint_select_o,
  output logic fifo_pop_o,
  output logic fifo_push_o,
  output logic [15:0] fifo_wdata_o,
  output logic fifo_word_o,
  output logic fifo_flush_o
);
  // ****************************************
  // Pin synchronisers and strobe decoding
  // ****************************************
  logic [3:0] pin_sync; // dma_acknowledge_in, eot, rd_n, wr_n
  logic [15:0] data_sync; // Bus data, same delay as strobes
  logic [3:0] pin_pol;
  logic [3:0] pin_act;
  logic [3:0] pin_rise;
  logic [3:0] pin_fall;
  logic [12:0] cfg_q; // Configuration register
  logic [15:0] cnt_reg_q; // Programmed byte count

  usbdma_sync #(.W(20)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({dma_acknowledge_in_i, end_of_transfer_in_i, rd_n_i, wr_n_i, bus_data_i}),
    .q_o({pin_sync, data_sync})
  );

  assign pin_pol = {cfg_q[usbdma_pkg::CFG_DMA_ACKNOWLEDGE_IN_POL_BIT],
                    cfg_q[usbdma_pkg::CFG_EOT_POL_BIT], 2'b00};

  usbdma_strobe #(.W(4)) u_strobe (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .lvl_i(pin_sync),
    .pol_i(pin_pol),
    .act_o(pin_act),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  // Named views of the decoded pins
  wire dma_acknowledge_in_act = pin_act[3];
  wire dma_acknowledge_in_fall = pin_fall[3];
  wire eot_rise = pin_rise[2];
  wire rd_act = pin_act[1];
  wire rd_fall = pin_fall[1];
  wire wr_act = pin_act[0];
  wire wr_fall = pin_fall[0];

  // ****************************************
  // Configuration views
  // ****************************************
  // endpoint code field
  wire [3:0] ep_idx = cfg_q[usbdma_pkg::CFG_EPIDX_LSB +: 4];
  wire en = cfg_q[usbdma_pkg::CFG_EN_BIT];
  wire cnt_en = cfg_q[usbdma_pkg::CFG_CNTEN_BIT];
  wire short_en = cfg_q[usbdma_pkg::CFG_SHORT_BIT];
  wire burst = cfg_q[usbdma_pkg::CFG_BURST_BIT];
  wire wide = cfg_q[usbdma_pkg::CFG_WIDE_BIT];
  wire dma_request_out_pol = cfg_q[usbdma_pkg::CFG_DMA_REQUEST_OUT_POL_BIT];
  wire ackm = cfg_q[usbdma_pkg::CFG_ACKMODE_BIT];
  // only codes of endpoints 1..14 are served
  wire ep_valid = (ep_idx >= usbdma_pkg::EP_FIRST_CODE) &&
                  (ep_idx <= usbdma_pkg::EP_LAST_CODE);
  // direction bit high means DMA writes the FIFO
  wire dir_wr = endpoint_direction_bit_i;
  wire [4:0] step = wide ? 5'h02 : 5'h01;

  // ****************************************
  // Wishbone slave decode
  // ****************************************
  logic ack_q;
  logic [31:0] rdat_q;
  logic done_q; // Sticky run-ended flag
  logic [1:0] why_q; // Why the last run ended
  logic [15:0] cnt_q; // Live byte counter
  usbdma_pkg::usbdma_state_t state_q;
  usbdma_pkg::usbdma_state_t state_d;
  logic [31:0] sel_mask;

  // Byte-lane mask from the select lines
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_lane
      assign sel_mask[gb*8 +: 8] = {8{wb_sel_i[gb]}};
    end
  endgenerate

  wire bus_req = wb_cyc_i && wb_stb_i && !ack_q;
  wire wr_req = bus_req && wb_we_i;
  wire hit_cfg = wb_adr_i == usbdma_pkg::REG_CFG_OFF;
  wire hit_cnt = wb_adr_i == usbdma_pkg::REG_CNT_OFF;
  wire hit_stat = wb_adr_i == usbdma_pkg::REG_STAT_OFF;
  wire [31:0] cfg_wide = {19'h00000, cfg_q};
  wire [31:0] cfg_merge = (cfg_wide & ~sel_mask) | (wb_dat_i & sel_mask);
  wire [31:0] cnt_merge = ({16'h0000, cnt_reg_q} & ~sel_mask) | (wb_dat_i & sel_mask);
  wire cfg_wr = wr_req && hit_cfg;
  // Enable written from zero to one starts a run
  wire en_rise = cfg_wr && cfg_merge[usbdma_pkg::CFG_EN_BIT] && !en;
  wire done_clr = wr_req && hit_stat && wb_sel_i[2] && wb_dat_i[usbdma_pkg::STAT_DONE_BIT];
  wire [31:0] stat_word = {12'h000, why_q, done_q, state_q == usbdma_pkg::USBDMA_RUN, cnt_q};
  // Unmapped offsets read as zero and still acknowledge
  wire [31:0] rd_mux = hit_cfg ? cfg_wide :
                       hit_cnt ? {16'h0000, cnt_reg_q} :
                       hit_stat ? stat_word : 32'h0000_0000;

  // ****************************************
  // Transfer events
  // ****************************************
  wire running = state_q == usbdma_pkg::USBDMA_RUN;
  // fly-by item completes on strobe release
  wire fly_done = !ackm && dma_acknowledge_in_act && (dir_wr ? wr_fall : rd_fall);
  // acknowledge release is the strobe here
  wire ack_done = ackm && dma_acknowledge_in_fall;
  wire xfer_done = running && (fly_done || ack_done);
  wire xfer_rd = xfer_done && !dir_wr;
  wire xfer_wr = xfer_done && dir_wr;

  // count runs out on this item
  wire cnt_end = cnt_en && xfer_done && (cnt_q <= {11'h000, step});
  wire short_end = short_en && !dir_wr && short_packet_i && !fifo_has_data_i;
  wire pin_end = running && eot_rise;
  wire off_end = running && !en;
  wire run_end = pin_end || off_end || (running && (cnt_end || short_end));
  wire [1:0] why_d = pin_end ? usbdma_pkg::END_PIN :
                     off_end ? usbdma_pkg::END_OFF :
                     cnt_end ? usbdma_pkg::END_COUNT : usbdma_pkg::END_SHORT;

  // ****************************************
  // Request pacing
  // ****************************************
  logic hold_q; // Request withheld until acknowledge drops
  logic [4:0] burst_q; // Bytes moved in this DMA cycle
  logic req_q; // Active-true request
  wire [4:0] burst_next = burst_q + step;
  // single drops each item, burst at the limit
  wire cycle_end = xfer_done && (!burst || burst_next >= usbdma_pkg::BURST_MAX_BYTES);
  // FIFO has data to read out or room to fill
  wire fifo_ready = dir_wr ? fifo_has_room_i : fifo_has_data_i;
  wire req_d = running && en && ep_valid && fifo_ready && !hold_q && !cycle_end && !run_end;

  // ****************************************
  // Bus drive and capture
  // ****************************************
  logic [15:0] hold_data_q; // Bus data seen while strobe active
  // drive only while acknowledge is active
  wire oe_d = dma_acknowledge_in_act && ep_valid && !dir_wr &&
              (state_q != usbdma_pkg::USBDMA_IDLE) && (ackm ? 1'b1 : rd_act);
  wire wr_strobe = ackm ? dma_acknowledge_in_act : (dma_acknowledge_in_act && wr_act);

  // ****************************************
  // Sequencer next state
  // ****************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      usbdma_pkg::USBDMA_IDLE: begin
        // Start once enabled
        if (en) begin
          state_d = usbdma_pkg::USBDMA_RUN;
        end
      end
      usbdma_pkg::USBDMA_RUN: begin
        // Any end condition stops the run
        if (run_end) begin
          state_d = usbdma_pkg::USBDMA_DRAIN;
        end
      end
      usbdma_pkg::USBDMA_DRAIN: begin
        // Let the controller finish its acknowledge
        if (!dma_acknowledge_in_act) begin
          state_d = usbdma_pkg::USBDMA_IDLE;
        end
      end
      default: begin
        state_d = usbdma_pkg::USBDMA_IDLE;
      end
    endcase
  end

  // ****************************************
  // Register file and bus answer
  // ****************************************
  // Ack is a single cycle pulse, data from a flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= bus_req;
      rdat_q <= bus_req ? rd_mux : 32'h0000_0000;
    end
  end

  // Software write wins over the hardware enable clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= usbdma_pkg::CFG_RESET;
    end else if (cfg_wr) begin
      cfg_q <= cfg_merge[12:0];
    end else if (run_end) begin
      // Hardware end clears enable, no interrupt raised
      cfg_q[usbdma_pkg::CFG_EN_BIT] <= 1'b0;
    end
  end

  // Programmed count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg_q <= usbdma_pkg::CNT_RESET;
    end else if (wr_req && hit_cnt) begin
      cnt_reg_q <= cnt_merge[15:0];
    end
  end

  // Done flag: a set in the clearing cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_q <= 1'b0;
      why_q <= usbdma_pkg::END_PIN;
    end else if (run_end) begin
      done_q <= 1'b1;
      why_q <= why_d;
    end else if (done_clr) begin
      done_q <= 1'b0;
    end
  end

  // ****************************************
  // Sequencer, counter and pacing state
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= usbdma_pkg::USBDMA_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // load on enable, count down by item size
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 16'h0000;
    end else if (en_rise) begin
      cnt_q <= cnt_reg_q;
    end else if (xfer_done) begin
      cnt_q <= (cnt_q > {11'h000, step}) ? cnt_q - {11'h000, step} : 16'h0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_q <= 1'b0;
      burst_q <= 5'h00;
    end else if (cycle_end) begin
      hold_q <= 1'b1;
      burst_q <= 5'h00;
    end else if (xfer_done) begin
      burst_q <= burst_next;
    end else if (!dma_acknowledge_in_act) begin
      hold_q <= 1'b0;
    end
  end

  // request pin polarity applied at the output flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_q <= 1'b0;
      // Reset polarity is active low, so the idle pin level is high
      dma_request_out_o <= 1'b1;
    end else begin
      req_q <= req_d;
      dma_request_out_o <= dma_request_out_pol ? req_d : ~req_d;
    end
  end

  // ****************************************
  // Data path and FIFO side
  // ****************************************
  // Capture bus while a write strobe is active
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_data_q <= 16'h0000;
    end else if (wr_strobe) begin
      hold_data_q <= data_sync;
    end
  end

  // acknowledge steers the FIFO port to DMA
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dma_endpoint_select_o <= 4'h0;
      dma_endpoint_index_o <= 4'h0;
      fifo_word_o <= 1'b0;
    end else begin
      dma_endpoint_select_o <= dma_acknowledge_in_act ? ep_idx : cpu_ep_select_i;
      dma_endpoint_index_o <= ep_idx;
      fifo_word_o <= wide;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_data_o <= 16'h0000;
      bus_data_oe_o <= 1'b0;
    end else begin
      bus_data_o <= oe_d ? fifo_rdata_i : 16'h0000;
      bus_data_oe_o <= oe_d;
    end
  end

  // pop on read items, push on write items
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fifo_pop_o <= 1'b0;
      fifo_push_o <= 1'b0;
      fifo_wdata_o <= 16'h0000;
      fifo_flush_o <= 1'b0;
    end else begin
      fifo_pop_o <= xfer_rd;
      fifo_push_o <= xfer_wr;
      fifo_wdata_o <= xfer_wr ? hold_data_q : fifo_wdata_o;
      // pin end on receive discards active buffer
      fifo_flush_o <= pin_end && !dir_wr;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_route_dma_ep: assert property (dma_acknowledge_in_act |=> dma_endpoint_select_o == $past(ep_idx))
    else $error("acknowledge did not route the DMA endpoint");
  a_oe_drop_ack: assert property (!dma_acknowledge_in_act |=> !bus_data_oe_o)
    else $error("bus driven without acknowledge");
  a_single_drop: assert property (xfer_done && !burst |=> !req_q ##1 !req_q)
    else $error("request kept after single item");
  a_burst_limit: assert property (burst_q < usbdma_pkg::BURST_MAX_BYTES)
    else $error("burst exceeded sixteen bytes");
  a_ack_strobe_push: assert property (fifo_push_o && $past(ackm) |-> $past(dma_acknowledge_in_fall))
    else $error("push in ack mode without acknowledge release");
  a_dir_pop: assert property (fifo_pop_o |-> !$past(dir_wr))
    else $error("pop on a transmit endpoint");
  a_eot_stop: assert property (pin_end |=> state_q == usbdma_pkg::USBDMA_DRAIN && !req_q)
    else $error("run continued after end pin");
  a_flush_rx: assert property (pin_end && !dir_wr |=> fifo_flush_o ##1 !fifo_flush_o)
    else $error("receive buffer not flushed once");
  a_count_load: assert property (en_rise |=> cnt_q == $past(cnt_reg_q))
    else $error("counter not loaded on enable");
  a_disable_stop: assert property (off_end |=> !running && !en)
    else $error("run kept after enable cleared");
  a_req_polar: assert property (dma_request_out_o == (req_q ~^ $past(dma_request_out_pol)))
    else $error("request pin polarity wrong");
  a_req_valid_ep: assert property (req_q |-> $past(ep_valid && fifo_ready))
    else $error("request without valid endpoint or FIFO need");

  c_burst_cycle: cover property (xfer_done && burst && cycle_end);
  c_ack_mode_item: cover property (xfer_done && ackm);
  c_count_end: cover property (running && cnt_end);
  c_pin_end_rx: cover property (pin_end && !dir_wr);
endmodule : usbdma_port

/* verification/usbdma_ctl_model.sv */
`timescale 1ns/1ps
// ****************************************
// External fly-by DMA controller model
// ****************************************
module usbdma_ctl_model (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic req_pol_i,
  input wire logic [15:0] bus_i,
  output logic dma_acknowledge_in_n_o,
  output logic eot_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [15:0] bus_o
);
  int slow = 0; // Extra strobe hold, set by the bench for slow runs
  logic drv = 1'b0; // High while this side drives the data lines
  logic [15:0] wval = 16'h0000; // Value put out on a write item
  initial begin
    dma_acknowledge_in_n_o = 1'b1;
    eot_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    bus_o = 16'h0000;
  end
  // Released lines toggle so a stale value can never look valid
  always @(posedge clk_i) begin
    bus_o <= drv ? wval : ~bus_o;
  end
  // One byte or word item; strobes and ack change only after an edge
  task item(input logic wr, input logic ackm, input logic [15:0] wd,
            output logic [15:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    rd = 16'hxxxx;
    for (n = 0; n < 200 && !ok; n++) begin
      @(negedge clk_i);
      ok = (req_i === req_pol_i);
    end
    if (ok) begin
      @(posedge clk_i);
      dma_acknowledge_in_n_o <= 1'b0;
      drv <= wr;
      wval <= wd;
      @(posedge clk_i);
      if (!ackm) begin
        rd_n_o <= wr;
        wr_n_o <= !wr;
      end
      repeat (5 + slow) @(posedge clk_i);
      @(negedge clk_i);
      rd = bus_i;
      @(posedge clk_i);
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      // Fly-by keeps ack past the strobe release; ack mode drops it here
      dma_acknowledge_in_n_o <= ackm;
      repeat (4) @(posedge clk_i);
      dma_acknowledge_in_n_o <= 1'b1;
      drv <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask : item
  task pulse_eot();
    @(posedge clk_i);
    eot_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    eot_n_o <= 1'b1;
  endtask : pulse_eot
endmodule : usbdma_ctl_model

/* verification/tb_usbdma_port.sv */
`timescale 1ns/1ps
// ****************************************
// Self-checking bench of the DMA port
// ****************************************
module tb_usbdma_port;
  localparam logic [31:0] EN = 32'h1 << usbdma_pkg::CFG_EN_BIT;
  localparam logic [31:0] CNTE = 32'h1 << usbdma_pkg::CFG_CNTEN_BIT;
  localparam logic [31:0] SHE = 32'h1 << usbdma_pkg::CFG_SHORT_BIT;
  localparam logic [31:0] BUR = 32'h1 << usbdma_pkg::CFG_BURST_BIT;
  localparam logic [31:0] WID = 32'h1 << usbdma_pkg::CFG_WIDE_BIT;
  localparam logic [31:0] RPOL = 32'h1 << usbdma_pkg::CFG_DMA_REQUEST_OUT_POL_BIT;
  localparam logic [31:0] ACKM = 32'h1 << usbdma_pkg::CFG_ACKMODE_BIT;
  logic clk_i = 1'b0, rst_i = 1'b1; // Clock and reset
  logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0; // Bus request
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf; // All lanes always
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rv; // Bus data
  logic wb_ack_o, req, oe, pop, push, word, flush, dma_acknowledge_in_n, eot_n, rd_n, wr_n;
  logic [15:0] pin_in, bus_data_o, wdat, fifo_rdata_i = 16'h1234, d;
  logic [3:0] cpu_sel = 4'h5, idx, sel, ep = 4'h2; // Select lines
  logic dir = 0, has_data = 0, has_room = 0, short = 0, req_pol = 0, ok;
  int n_errors = 0, n_checks = 0, n_pop = 0, n_push = 0, n_flush = 0;
  int n_fall = 0, oe_run = 0, k, base, fall0;
  always #25 clk_i = ~clk_i;
  usbdma_port u_usbdma_port (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .dma_request_out_o(req), .dma_acknowledge_in_i(dma_acknowledge_in_n), .end_of_transfer_in_i(eot_n),
    .rd_n_i(rd_n), .wr_n_i(wr_n), .bus_data_i(pin_in), .bus_data_o(bus_data_o),
    .bus_data_oe_o(oe), .cpu_ep_select_i(cpu_sel), .dma_endpoint_index_o(idx),
    .endpoint_direction_bit_i(dir), .fifo_has_data_i(has_data),
    .fifo_has_room_i(has_room), .short_packet_i(short), .fifo_rdata_i(fifo_rdata_i),
    .dma_endpoint_select_o(sel), .fifo_pop_o(pop), .fifo_push_o(push),
    .fifo_wdata_o(wdat), .fifo_word_o(word), .fifo_flush_o(flush));
  usbdma_ctl_model u_usbdma_ctl_model (.clk_i(clk_i), .req_i(req), .req_pol_i(req_pol),
    .bus_i(bus_data_o), .dma_acknowledge_in_n_o(dma_acknowledge_in_n), .eot_n_o(eot_n), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .bus_o(pin_in));
  // FIFO stand-in: head steps on every pop; pulses and request drops are counted
  always @(posedge clk_i) begin
    if (pop === 1'b1) fifo_rdata_i <= fifo_rdata_i + 16'h0101;
    n_pop += (pop === 1'b1);
    n_push += (push === 1'b1);
    n_flush += (flush === 1'b1);
  end
  always @(req) if (!rst_i && req === !req_pol) n_fall++;
  // Mid-item the data path must point at the DMA endpoint
  always @(negedge clk_i) begin
    oe_run = (oe === 1'b1) ? oe_run + 1 : 0;
    if (oe_run == 2) chk(sel, ep, "dma select");
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  // Classic single Wishbone cycle, released after ack is seen
  task wb(input logic we, input logic [3:0] adr, input logic [31:0] wd);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    if (n == 20) begin
      n_errors++;
      tally_and_finish();
    end
    // Ack and read data are taken at the same rising edge
    rv = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask : wb
  // Poll until the run has ended, check why, then clear done
  task done_is(input logic [2:0] exp);
    int n;
    for (n = 0; n < 40; n++) begin
      wb(0, usbdma_pkg::REG_STAT_OFF, 32'h0);
      if (rv[usbdma_pkg::STAT_DONE_BIT] === 1'b1) break;
    end
    if (n == 40) begin
      n_errors++;
      tally_and_finish();
    end
    chk(rv[19:17], exp, "end reason");
    wb(1, usbdma_pkg::REG_STAT_OFF, 32'h1 << usbdma_pkg::STAT_DONE_BIT);
  endtask : done_is
  // Run n items of one kind and check read data against the FIFO head
  task items(input int n, input logic wr, input logic ackm);
    base = fifo_rdata_i;
    for (k = 0; k < n; k++) begin
      u_usbdma_ctl_model.item(wr, ackm, 16'h00a0 + k[15:0], d, ok);
      chk(ok, 1'b1, "request seen");
      if (!ok) tally_and_finish();
      if (!wr && ackm) chk(d, base[15:0] + 16'h0101 * k[15:0], "ack mode data");
      if (!wr && !ackm) chk(d, base[15:0] + 16'h0101 * k[15:0], "fly-by data");
    end
  endtask : items
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    repeat (3) @(posedge clk_i);
    chk(req, 1'b1, "request idle");
    chk(oe, 1'b0, "oe idle");
    chk(sel, cpu_sel, "select reset");
    wb(0, usbdma_pkg::REG_CFG_OFF, 32'h0);
    chk(rv, 32'h0, "cfg reset");
    wb(0, 4'hc, 32'h0);
    chk(rv, 32'h0, "unmapped");
    $display("test reset done");
    has_data <= 1;
    wb(1, usbdma_pkg::REG_CFG_OFF, EN | WID | ep);
    @(negedge clk_i);
    chk(idx, ep, "index");
    chk(sel, cpu_sel, "cpu select");
    chk(word, 1'b1, "word items");
    items(2, 0, 0);
    chk(n_pop, 2, "pops single");
    chk(n_fall, 2, "single drops");
    wb(1, usbdma_pkg::REG_CFG_OFF, 32'h0);
    done_is(3'b111);
    chk(oe, 1'b0, "oe after ack");
    $display("test fly-by read done");
    dir <= 1;
    has_data <= 0;
    has_room <= 1;
    ep = 4'hf;
    u_usbdma_ctl_model.slow = 6;
    wb(1, usbdma_pkg::REG_CNT_OFF, 32'h3);
    wb(1, usbdma_pkg::REG_CFG_OFF, EN | CNTE | ep);
    @(negedge clk_i);
    chk(idx, 4'hf, "index top");
    items(3, 1, 0);
    chk(n_push, 3, "pushes");
    chk(n_pop, 2, "no pop on write");
    chk(wdat[7:0], 8'ha2, "write data");
    done_is(3'b011);
    wb(0, usbdma_pkg::REG_CFG_OFF, 32'h0);
    chk(rv[usbdma_pkg::CFG_EN_BIT], 1'b0, "enable cleared");
    $display("test counted write done");
    u_usbdma_ctl_model.slow = 0;
    dir <= 0;
    has_data <= 1;
    ep = 4'h2;
    wb(1, usbdma_pkg::REG_CFG_OFF, EN | ACKM | WID | ep);
    items(2, 0, 1);
    chk(n_pop, 4, "ack mode pops");
    u_usbdma_ctl_model.pulse_eot();
    done_is(3'b001);
    chk(n_flush, 1, "flush");
    $display("test ack strobe done");
    fall0 = n_fall;
    wb(1, usbdma_pkg::REG_CFG_OFF, EN | BUR | ep);
    items(16, 0, 0);
    chk(n_fall - fall0, 1, "burst drops");
    wb(1, usbdma_pkg::REG_CFG_OFF, 32'h0);
    done_is(3'b111);
    $display("test burst done");
    has_data <= 0;
    short <= 1;
    wb(1, usbdma_pkg::REG_CFG_OFF, EN | SHE | ep);
    done_is(3'b101);
    short <= 0;
    $display("test short packet done");
    has_data <= 1;
    req_pol <= 1;
    wb(1, usbdma_pkg::REG_CFG_OFF, EN | RPOL | 32'h1);
    repeat (20) @(posedge clk_i);
    chk(req, 1'b0, "code one idle");
    $display("test polarity done");
    tally_and_finish();
  end
endmodule : tb_usbdma_port
